/* File: core/external_bus_master_cycles.sv */
/*
  External bus master sequencer: runs internal requests as external read and
  write cycles (first state, wait states, second state) or as internal cycles
  with optional show cycles, with a Wishbone slave for its settings.
  Assumes requests come from logic on clk_i; pin inputs are asynchronous.
*/
// Overview of operation
// R1: Strobes byte enables, write enables if selected
// R2: Strobe 0..3 map D[31:24]..D[7:0]
// R3: Read strobe asserted on every external read
// R4: Read first state drives address, direction, codes
// R5: Read strobe and lane strobes during first state
// R6: Early acknowledge goes straight to second state
// R7: Whole-clock wait states until acknowledge arrives
// R8: Read half-words passed to internal data
// R9: Read signals held through second state
// R10: Slave releases data after read strobe negates
// R11: Write first state: codes, select, direction low
// R12: Write data from first wait or second
// R13: Write lane strobes negated in second state
// R14: Error termination wins over acknowledge
// R15: Bus monitor timeout raises internal error
// R16: Aborted cycle still drives address and codes
// R17: Emulation space code driven on pins
// R18: Space code by address region, reset 11
// R19: Space code valid only in cycles, reset
// R20: Internal cycles drive codes, data bus released
// R21: Show cycles present data, strobes negated
// R22: Show cycles forced by emulation, else software
// R23: Word to 16-bit port splits two cycles
// R24: Inputs sampled on clock, strobes negated after reset
`timescale 1ns/1ps
module external_bus_master_cycles
  import external_bus_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        req_valid_i,
  input  wire req_type     req_i,
  output logic             req_ready_o,
  input  wire logic        cs_ack_i,
  input  wire logic        abort_i,
  output answer_type       answer_o,
  input  wire logic        transfer_ack_n_i,
  input  wire logic        transfer_error_ack_n_i,
  input  wire logic [31:0] data_i,
  output pins_type         pins_o
);

  typedef struct packed {
    phase_type   phase;
    req_type     req;
    logic        upper;
    logic        err;
    logic        abort;
    logic [6:0]  mon;
    logic        ack_meta;
    logic        ack_sync;
    logic        err_meta;
    logic        err_sync;
    logic [31:0] d_meta;
    logic [31:0] d_sync;
    logic [1:0]  esc;
    logic        show_cycle_enable;
    logic [1:0]  monitor_timeout_select;
    logic        emulation_mode;
    logic        wb_ack;
    logic [31:0] wb_dat;
    answer_type  ans;
  } state_type;

  localparam state_type RESET_STATE = '{
    phase: PH_IDLE, req: '0, upper: 1'b0, err: 1'b0, abort: 1'b0, mon: 7'h00,
    ack_meta: 1'b1, ack_sync: 1'b1, err_meta: 1'b1, err_sync: 1'b1,
    d_meta: 32'h0000_0000, d_sync: 32'h0000_0000, esc: ESC_REGS,
    show_cycle_enable: SHOW_RESET, monitor_timeout_select: TMO_RESET,
    emulation_mode: EMU_RESET, wb_ack: 1'b0, wb_dat: 32'h0000_0000, ans: '0};

  state_type st;
  state_type next_st;

  function automatic logic [3:0] lanes_of(input req_type r);
    if (r.port16) begin
      if (r.size == SIZE_BYTE) lanes_of = r.addr[0] ? 4'h2 : 4'h1;
      else lanes_of = 4'h3;
    end else if (r.size == SIZE_BYTE) begin
      lanes_of = 4'h1 << r.addr[1:0];
    end else if (r.size == SIZE_HALF) begin
      lanes_of = r.addr[1] ? 4'hc : 4'h3;
    end else begin
      lanes_of = 4'hf;
    end
  endfunction

  function automatic logic [1:0] esc_of(input logic [31:0] a);
    if (a >= EXT_LOW) esc_of = ESC_EXTERNAL;
    else if (a >= PORTS_LOW && a <= PORTS_HIGH) esc_of = ESC_PORTS;
    else if (a > PORTS_HIGH && a <= REGS_HIGH) esc_of = ESC_REGS;
    else esc_of = ESC_INTERNAL;
  endfunction

  logic       ext;
  logic       show_on;
  logic       split;
  logic [6:0] mon_limit;
  logic       timeout;
  logic       ack_in;
  logic       err_in;
  logic       wb_req;

  assign ext       = (st.phase == PH_FIRST) || (st.phase == PH_WAIT) || (st.phase == PH_SECOND);
  assign show_on   = st.emulation_mode || st.show_cycle_enable;  // R22
  assign split     = st.req.port16 && (st.req.size == SIZE_WORD);  // R23
  assign mon_limit = MON_BASE << st.monitor_timeout_select;
  assign timeout   = (st.mon == mon_limit - 7'h01);  // R15
  assign ack_in    = !st.ack_sync || cs_ack_i;  // R6 R7 R24
  assign err_in    = !st.err_sync || timeout;  // R14 R15
  assign wb_req    = wb_cyc_i && wb_stb_i && !st.wb_ack;
  assign req_ready_o = (st.phase == PH_IDLE);
  assign wb_ack_o  = st.wb_ack;
  assign wb_dat_o  = st.wb_dat;
  assign answer_o  = st.ans;

  always_comb begin
    next_st = st;
    next_st.ack_meta = transfer_ack_n_i;  // R24
    next_st.ack_sync = st.ack_meta;
    next_st.err_meta = transfer_error_ack_n_i;
    next_st.err_sync = st.err_meta;
    next_st.d_meta   = data_i;
    next_st.d_sync   = st.d_meta;
    next_st.ans.done = 1'b0;
    next_st.wb_ack   = wb_req;
    if (wb_req) begin
      if (wb_adr_i == CTRL_OFFSET) begin
        next_st.wb_dat = {28'h0000000, st.emulation_mode, st.monitor_timeout_select, st.show_cycle_enable};
        if (wb_we_i && wb_sel_i[0]) begin
          next_st.show_cycle_enable      = wb_dat_i[CTRL_SHOW_BIT];  // R22
          next_st.monitor_timeout_select = wb_dat_i[CTRL_TMO_LSB +: 2];
          next_st.emulation_mode         = wb_dat_i[CTRL_EMU_BIT];
        end
      end else if (wb_adr_i == STATUS_OFFSET) begin
        next_st.wb_dat = {29'h0000000, st.ans.aborted, st.ans.error, !req_ready_o};
      end else begin
        next_st.wb_dat = 32'h0000_0000;
      end
    end
    unique case (st.phase)
      PH_IDLE: begin
        if (req_valid_i) begin
          next_st.req   = req_i;
          next_st.upper = 1'b0;
          next_st.err   = 1'b0;
          next_st.abort = 1'b0;
          next_st.mon   = 7'h00;
          next_st.esc   = esc_of(req_i.addr);  // R17 R18
          next_st.phase = req_i.internal ? PH_INTERNAL : PH_FIRST;
        end
      end
      PH_FIRST, PH_WAIT: begin
        if (err_in || ack_in || abort_i) begin
          next_st.phase = PH_SECOND;  // R6
          next_st.err   = err_in;  // R14
          next_st.abort = abort_i && !err_in;
        end else begin
          next_st.phase = PH_WAIT;  // R7
          next_st.mon   = st.mon + 7'h01;
        end
      end
      PH_SECOND: begin
        if (!st.req.we) begin
          if (!st.req.port16) next_st.ans.rdata = st.d_sync;  // R8
          else if (st.upper || st.req.addr[1]) next_st.ans.rdata[15:0] = st.d_sync[31:16];
          else next_st.ans.rdata[31:16] = st.d_sync[31:16];
        end
        if (split && !st.upper && !st.err && !st.abort) begin
          next_st.phase = PH_FIRST;  // R23
          next_st.upper = 1'b1;
          next_st.mon   = 7'h00;
        end else begin
          next_st.phase       = PH_IDLE;
          next_st.ans.done    = 1'b1;
          next_st.ans.error   = st.err;
          next_st.ans.aborted = st.abort;
        end
      end
      PH_INTERNAL: begin
        next_st.ans.done    = 1'b1;
        next_st.ans.error   = 1'b0;
        next_st.ans.aborted = 1'b0;
        next_st.ans.rdata   = st.req.data;
        next_st.phase       = show_on ? PH_SHOW : PH_IDLE;  // R21
      end
      PH_SHOW: begin
        next_st.phase = PH_IDLE;
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= RESET_STATE;  // R24
    end else begin
      st <= next_st;
    end
  end

  logic lane_on;

  always_comb begin
    pins_o.addr = st.req.addr[22:0];  // R4 R11 R16 R20
    pins_o.addr[1] = st.req.addr[1] || st.upper;  // R23
    pins_o.size = st.upper ? SIZE_HALF : st.req.size;
    pins_o.access_type_code = st.req.access_type_code;
    pins_o.dir = !st.req.we;  // R4 R11
    pins_o.emulation_space_code = st.esc;  // R19
    pins_o.read_strobe_n = !(ext && !st.req.we);  // R3 R5 R9 R16
    pins_o.device_select_n = ext ? ~st.req.cs_match : 4'hf;  // R4 R9 R11
    if (st.req.we) lane_on = ext && (st.phase != PH_SECOND) && !st.abort;  // R11 R13
    else lane_on = ext && !st.req.cs_we && !st.abort;  // R1 R5 R9
    pins_o.byte_lane_strobe_n = lane_on ? ~lanes_of(st.req) : 4'hf;  // R2 R21
    if (st.phase == PH_SHOW) pins_o.data = st.ans.rdata;  // R21
    else if (st.req.port16 && (st.upper || st.req.addr[1])) pins_o.data = {2{st.req.data[15:0]}};
    else pins_o.data = st.req.data;
    if (st.phase == PH_SHOW) pins_o.data_oe = 32'hffff_ffff;  // R20
    else if (st.req.we && ((st.phase == PH_WAIT) || (st.phase == PH_SECOND))) pins_o.data_oe = 32'hffff_ffff;  // R12
    else pins_o.data_oe = 32'h0000_0000;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_READ_STROBE: assert property (ext && !st.req.we |-> !pins_o.read_strobe_n)  // R3
    else $error("read strobe not asserted in external read");
  AST_EARLY_ACK: assert property ((st.phase == PH_FIRST) && ack_in |=> st.phase == PH_SECOND)  // R6
    else $error("acknowledge in first state did not reach second state");
  AST_WAIT_STATE: assert property ((st.phase == PH_FIRST) && !ack_in && !err_in && !abort_i
    |=> st.phase == PH_WAIT)  // R7
    else $error("missing wait state without acknowledge");
  AST_HOLD_READ: assert property ((st.phase == PH_SECOND) && !st.req.we && !st.abort
    |-> $stable(pins_o.addr) && $stable(pins_o.byte_lane_strobe_n) && !pins_o.read_strobe_n)  // R9
    else $error("read signals changed in second state");
  AST_BYTE_LANE: assert property ((st.phase == PH_FIRST) && st.req.we && !st.req.port16
    && (st.req.size == SIZE_BYTE) |-> pins_o.byte_lane_strobe_n == ~(4'h1 << st.req.addr[1:0]))  // R2
    else $error("byte lane strobe mapping wrong");
  AST_WRITE_DATA: assert property ((st.phase == PH_WAIT) && st.req.we |-> pins_o.data_oe == 32'hffff_ffff)  // R12
    else $error("write data not driven in wait state");
  AST_WRITE_NEGATE: assert property ((st.phase == PH_SECOND) && st.req.we |-> pins_o.byte_lane_strobe_n == 4'hf)  // R13
    else $error("write lane strobes active in second state");
  AST_ERROR_WINS: assert property ((st.phase == PH_WAIT) && timeout && ack_in && !split
    |-> ##2 st.ans.done && st.ans.error)  // R14
    else $error("error termination lost to acknowledge");
  AST_TIMEOUT: assert property ((st.phase == PH_WAIT) && (st.mon == mon_limit - 7'h01)
    |=> (st.phase == PH_SECOND) && st.err)  // R15
    else $error("bus monitor failed to end the cycle");
  AST_SPACE_EXT: assert property (req_ready_o && req_valid_i && req_i.addr[31] |=> st.esc == ESC_EXTERNAL)  // R18
    else $error("space code not external for high address");
  AST_SHOW: assert property ((st.phase == PH_INTERNAL) && show_on
    |=> pins_o.data_oe == 32'hffff_ffff && pins_o.byte_lane_strobe_n == 4'hf && pins_o.read_strobe_n)  // R21
    else $error("show cycle not presented");
  AST_SPLIT: assert property ((st.phase == PH_SECOND) && split && !st.upper && !st.err && !st.abort
    |=> (st.phase == PH_FIRST) && pins_o.addr[1] && (pins_o.size == SIZE_HALF))  // R23
    else $error("second half of split word wrong");

  // Strobes and selects outside external cycles
  AST_LANE_IDLE: assert property (!ext |-> pins_o.byte_lane_strobe_n == 4'hf)  // R24 R21
    else $error("lane strobes active outside external cycle");
  AST_SELECT_IDLE: assert property (!ext |-> pins_o.device_select_n == 4'hf)  // R24
    else $error("device select active outside external cycle");
  AST_READ_STROBE_IDLE: assert property (!ext |-> pins_o.read_strobe_n)  // R21
    else $error("read strobe active outside external cycle");

  // Direction and read strobe per cycle kind
  AST_WRITE_NO_READ: assert property (ext && st.req.we |-> pins_o.read_strobe_n)  // R11
    else $error("read strobe active in write cycle");
  AST_DIR_READ: assert property (ext && !st.req.we |-> pins_o.dir)  // R4
    else $error("direction low in read cycle");
  AST_DIR_WRITE: assert property (ext && st.req.we |-> !pins_o.dir)  // R11
    else $error("direction high in write cycle");
  AST_READ_NO_DRIVE: assert property (ext && !st.req.we |-> pins_o.data_oe == 32'h0000_0000)  // R4
    else $error("data driven during read cycle");

  // Lane strobe encodings
  AST_WE_STROBES: assert property (ext && !st.req.we && st.req.cs_we
    |-> pins_o.byte_lane_strobe_n == 4'hf)  // R1
    else $error("write-enable strobes active in read");
  AST_WRITE_FIRST_LANES: assert property ((st.phase == PH_FIRST) && st.req.we
    |-> pins_o.byte_lane_strobe_n != 4'hf)  // R11
    else $error("no lane strobe in first write state");
  AST_WORD_LANES: assert property ((st.phase == PH_FIRST) && !st.req.port16 && (st.req.size == SIZE_WORD)
    && (st.req.we || !st.req.cs_we) |-> pins_o.byte_lane_strobe_n == 4'h0)  // R2 R5
    else $error("word access not on all lanes");
  AST_HALF_LANES: assert property ((st.phase == PH_FIRST) && st.req.we && !st.req.port16
    && (st.req.size == SIZE_HALF) |-> pins_o.byte_lane_strobe_n == (st.req.addr[1] ? 4'h3 : 4'hc))  // R2
    else $error("half-word lanes wrong");
  AST_PORT16_LANES: assert property ((st.phase == PH_FIRST) && st.req.we && st.req.port16
    && (st.req.size == SIZE_WORD) |-> pins_o.byte_lane_strobe_n == 4'hc)  // R2 R23
    else $error("narrow port word not on upper lanes");

  // Write data and hold
  AST_WRITE_FIRST_OFF: assert property ((st.phase == PH_FIRST) && st.req.we
    |-> pins_o.data_oe == 32'h0000_0000)  // R12
    else $error("write data driven in first state");
  AST_WRITE_SECOND_DATA: assert property ((st.phase == PH_SECOND) && st.req.we
    |-> pins_o.data_oe == 32'hffff_ffff)  // R12 R13
    else $error("write data not driven in second state");
  AST_HOLD_WRITE: assert property ((st.phase == PH_SECOND) && st.req.we
    |-> $stable(pins_o.addr) && $stable(pins_o.device_select_n) && $stable(pins_o.dir)
    && $stable(pins_o.access_type_code) && $stable(pins_o.size))  // R13
    else $error("write signals changed in second state");
  AST_HOLD_WRITE_DATA: assert property ((st.phase == PH_SECOND) && st.req.we && ($past(st.phase) == PH_WAIT)
    |-> $stable(pins_o.data))  // R13
    else $error("write data changed in second state");

  // Termination
  AST_ABORT_DRIVE: assert property ((st.phase == PH_SECOND) && st.abort
    |-> (pins_o.byte_lane_strobe_n == 4'hf) && (pins_o.read_strobe_n == st.req.we))  // R16
    else $error("aborted cycle pins wrong");
  AST_ABORT_DONE: assert property ((st.phase == PH_SECOND) && st.abort && !st.err
    |=> st.ans.done && st.ans.aborted)  // R16
    else $error("aborted cycle not reported");
  AST_ERR_PIN: assert property (((st.phase == PH_FIRST) || (st.phase == PH_WAIT)) && !st.err_sync
    |=> (st.phase == PH_SECOND) && st.err)  // R14
    else $error("error pin did not terminate cycle");
  AST_ERR_DONE: assert property ((st.phase == PH_SECOND) && st.err |=> st.ans.done && st.ans.error)  // R14
    else $error("error termination not reported");
  AST_MON_CLEAR: assert property (req_ready_o && req_valid_i |=> st.mon == 7'h00)  // R15
    else $error("bus monitor not cleared at cycle start");
  AST_WAIT_MON: assert property ((st.phase == PH_WAIT) && !ack_in && !err_in && !abort_i
    |=> (st.phase == PH_WAIT) && (st.mon == $past(st.mon) + 7'h01))  // R7 R15
    else $error("wait state did not count");
  AST_SPLIT_STOP: assert property ((st.phase == PH_SECOND) && split && !st.upper && (st.err || st.abort)
    |=> st.phase == PH_IDLE)  // R23
    else $error("split continued after failed half");

  // Space codes and internal cycles
  AST_SPACE_PORTS: assert property (req_ready_o && req_valid_i && (req_i.addr >= PORTS_LOW)
    && (req_i.addr <= PORTS_HIGH) |=> st.esc == ESC_PORTS)  // R18
    else $error("space code not ports");
  AST_SPACE_REGS: assert property (req_ready_o && req_valid_i && (req_i.addr > PORTS_HIGH)
    && (req_i.addr <= REGS_HIGH) |=> st.esc == ESC_REGS)  // R18
    else $error("space code not registers");
  AST_SPACE_INT: assert property (req_ready_o && req_valid_i && (req_i.addr < PORTS_LOW)
    |=> st.esc == ESC_INTERNAL)  // R18
    else $error("space code not internal");
  AST_INTERNAL_DONE: assert property ((st.phase == PH_INTERNAL) |=> st.ans.done)  // R20
    else $error("internal cycle not answered");
  AST_SHOW_OFF: assert property ((st.phase == PH_INTERNAL) && !show_on
    |=> (st.phase == PH_IDLE) && (pins_o.data_oe == 32'h0000_0000))  // R20 R22
    else $error("data bus driven with show cycles off");
  AST_SHOW_DATA: assert property ((st.phase == PH_SHOW) |-> pins_o.data == st.req.data)  // R21
    else $error("show cycle data wrong");

  COV_WAIT_READ: cover property ((st.phase == PH_WAIT) && !st.req.we ##1 st.phase == PH_SECOND);
  COV_SPLIT: cover property (st.upper && st.ans.done);
  COV_TIMEOUT: cover property (st.ans.done && st.ans.error);
  COV_SHOW: cover property (st.phase == PH_SHOW);
  COV_ABORT: cover property (st.ans.done && st.ans.aborted);

endmodule

/* File: shared/external_bus_pkg.sv */
/*
  Constants, codes and carrier types for the external bus master sequencer.
  Assumes one 25 MHz system clock and a classic Wishbone register port.
*/
package external_bus_pkg;

  typedef enum logic [5:0] {
    PH_IDLE     = 6'b000001,
    PH_FIRST    = 6'b000010,
    PH_WAIT     = 6'b000100,
    PH_SECOND   = 6'b001000,
    PH_INTERNAL = 6'b010000,
    PH_SHOW     = 6'b100000
  } phase_type;

  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;

  localparam logic [1:0] ESC_REGS     = 2'h3;
  localparam logic [1:0] ESC_PORTS    = 2'h2;
  localparam logic [1:0] ESC_INTERNAL = 2'h1;
  localparam logic [1:0] ESC_EXTERNAL = 2'h0;

  localparam logic [31:0] PORTS_LOW  = 32'h00c0_0000;
  localparam logic [31:0] PORTS_HIGH = 32'h00c0_ffff;
  localparam logic [31:0] REGS_HIGH  = 32'h00ff_ffff;
  localparam logic [31:0] EXT_LOW    = 32'h8000_0000;

  localparam logic [6:0] MON_BASE = 7'h08;

  localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam int          CTRL_SHOW_BIT = 0;
  localparam int          CTRL_TMO_LSB  = 1;
  localparam int          CTRL_EMU_BIT  = 3;
  localparam logic        SHOW_RESET    = 1'b0;
  localparam logic [1:0]  TMO_RESET     = 2'h0;
  localparam logic        EMU_RESET     = 1'b0;

  typedef struct packed {
    logic [31:0] addr;
    logic        we;
    logic [1:0]  size;
    logic [2:0]  access_type_code;
    logic [31:0] data;
    logic [3:0]  cs_match;
    logic        cs_we;
    logic        port16;
    logic        internal;
  } req_type;

  typedef struct packed {
    logic [22:0] addr;
    logic        dir;
    logic [1:0]  size;
    logic [2:0]  access_type_code;
    logic [3:0]  byte_lane_strobe_n;
    logic        read_strobe_n;
    logic [3:0]  device_select_n;
    logic [1:0]  emulation_space_code;
    logic [31:0] data;
    logic [31:0] data_oe;
  } pins_type;

  typedef struct packed {
    logic [31:0] rdata;
    logic        done;
    logic        error;
    logic        aborted;
  } answer_type;

endpackage

/* File: sim/bus_slave_model.sv */
/*
  Behavioural far-side slave: answers read and write cycles after a
  programmable delay, with normal, error or both terminations.
  Assumes the master's pins_type outputs and one clock shared with it.
*/
`timescale 1ns/1ps
module bus_slave_model
  import external_bus_pkg::*;
#(
  parameter logic [31:0] PATTERN = 32'h1234_5678
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire pins_type   pins_i,
  input  wire logic [7:0] delay_i,
  input  wire logic [1:0] mode_i,
  output logic            ack_n_o,
  output logic            err_n_o,
  output logic [31:0]     data_o
);
  logic       active;
  logic       hit;
  logic [7:0] count;

  assign active = !pins_i.read_strobe_n || (pins_i.byte_lane_strobe_n != 4'hf);
  // Delay of ff never answers
  assign hit    = active && (count == delay_i) && (delay_i != 8'hff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count   <= 8'h00;
      ack_n_o <= 1'b1;
      err_n_o <= 1'b1;
      data_o  <= ~PATTERN;
    end else begin
      count   <= !active ? 8'h00 : (count == delay_i ? count : count + 8'h01);
      ack_n_o <= !(hit && mode_i != 2'h1);
      err_n_o <= !(hit && mode_i != 2'h0);
      // Data while read strobe asserted, inverse once released
      data_o  <= pins_i.read_strobe_n ? ~PATTERN : PATTERN;
    end
  end
endmodule

/* File: sim/external_bus_master_cycles_bench.sv */
/*
  Self-checking bench for the external bus master sequencer.
  Assumes the slave model on the pins and Wishbone access to the settings.
*/
`timescale 1ns/1ps
module external_bus_master_cycles_bench
  import external_bus_pkg::*;
;
  localparam logic [31:0] PAT  = 32'h1234_5678;
  localparam logic [31:0] WDAT = 32'ha5c3_5a3c;
  typedef struct packed {
    logic [3:0]  lanes;
    logic        rd;
    logic        dir_low;
    logic        a1;
    logic [31:0] oe;
    logic [31:0] dat;
    logic [1:0]  esc;
    logic [7:0]  n;
  } seen_type;

  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic        cyc       = 1'b0;
  logic        wb_we     = 1'b0;
  logic [31:0] adr       = '0;
  logic [31:0] wdat      = '0;
  logic [31:0] rdat;
  logic        wb_ack;
  logic        req_valid = 1'b0;
  req_type     req       = '0;
  logic        ready;
  logic        cs_ack    = 1'b0;
  logic        abort     = 1'b0;
  answer_type  ans;
  answer_type  got;
  pins_type    pins;
  logic        ack_n;
  logic        err_n;
  logic [31:0] pin_data;
  logic [7:0]  delay     = 8'h00;
  logic [1:0]  mode      = 2'h0;
  logic [31:0] q;
  seen_type    s;
  int          fail_count = 0;
  int          tests_run  = 0;

  always #20 clk = ~clk;

  external_bus_master_cycles u_external_bus_master_cycles (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(wb_we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wb_ack), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(ready), .cs_ack_i(cs_ack), .abort_i(abort), .answer_o(ans),
    .transfer_ack_n_i(ack_n), .transfer_error_ack_n_i(err_n), .data_i(pin_data), .pins_o(pins));

  bus_slave_model #(.PATTERN(PAT)) u_bus_slave_model (
    .clk_i(clk), .rst_i(rst), .pins_i(pins), .delay_i(delay), .mode_i(mode),
    .ack_n_o(ack_n), .err_n_o(err_n), .data_o(pin_data));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One classic Wishbone cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    {cyc, wb_we, adr, wdat} <= {1'b1, w, a, d};
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50) fail_count++;
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk);
  endtask

  function automatic req_type mk(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic in);
    mk = '{addr: a, we: w, size: sz, access_type_code: 3'h4, data: WDAT, cs_match: 4'h1, internal: in, default: '0};
  endfunction

  // Runs one request and records what the pins showed until two cycles past done
  task automatic xfer(input req_type r);
    int post;
    post = 0;
    s = '{lanes: 4'hf, default: '0};
    req <= r;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    while (post < 3 && s.n < 200) begin
      @(negedge clk);
      if (s.n == 0) s.esc = pins.emulation_space_code;
      s.lanes &= pins.byte_lane_strobe_n;
      s.rd |= !pins.read_strobe_n;
      s.dir_low |= !pins.dir;
      s.a1 |= pins.addr[1];
      s.oe |= pins.data_oe;
      if (pins.data_oe != 0) s.dat = pins.data;
      if (post == 0) s.n++;
      if (ans.done) got = ans;
      if (ans.done || post != 0) post++;
    end
    if (s.n >= 200) fail_count++;
    @(posedge clk);
  endtask

  task t_reset;
    check(pins.byte_lane_strobe_n, 4'hf);
    check({pins.read_strobe_n, pins.device_select_n}, 5'h1f);
    check(pins.data_oe, 32'h0);
    check(pins.emulation_space_code, ESC_REGS);
    check(ready, 1'b1);
  endtask

  task t_regs;
    wb(1'b0, CTRL_OFFSET, 32'h0);
    check(q, 32'h0);
    wb(1'b1, CTRL_OFFSET, 32'h5);
    wb(1'b0, CTRL_OFFSET, 32'h0);
    check(q, 32'h5);
    wb(1'b0, 32'h10, 32'h0);
    check(q, 32'h0);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    check(q[0], 1'b0);
    wb(1'b1, CTRL_OFFSET, 32'h0);
  endtask

  task t_read;
    logic [1:0] sz [3] = '{SIZE_WORD, SIZE_BYTE, SIZE_HALF};
    logic [3:0] ln [3] = '{4'h0, 4'hd, 4'h3};
    delay = 8'h02;
    for (int i = 0; i < 3; i++) begin
      xfer(mk(EXT_LOW + i + (i / 2), 1'b0, sz[i], 1'b0));
      check(s.lanes, ln[i]);
      check({s.rd, s.dir_low, got.error}, 3'h4);
      check(s.esc, ESC_EXTERNAL);
    end
    check(got.rdata, PAT);
  endtask

  task t_write;
    req_type r;
    delay = 8'h03;
    xfer(mk(EXT_LOW + 32'h10, 1'b1, SIZE_WORD, 1'b0));
    check({s.lanes, s.rd, s.dir_low}, 6'h01);
    check(s.oe, 32'hffff_ffff);
    check(s.dat, WDAT);
    r = mk(EXT_LOW, 1'b0, SIZE_WORD, 1'b0);
    r.cs_we = 1'b1;
    xfer(r);
    check({s.lanes, s.rd}, 5'h1f);
  endtask

  task t_term;
    for (int m = 1; m < 3; m++) begin
      mode = m[1:0];
      delay = 8'h01;
      xfer(mk(EXT_LOW, 1'b0, SIZE_WORD, 1'b0));
      check(got.error, 1'b1);
    end
    mode = 2'h0;
    delay = 8'hff;
    cs_ack <= 1'b1;
    xfer(mk(EXT_LOW, 1'b0, SIZE_WORD, 1'b0));
    cs_ack <= 1'b0;
    check({s.n, got.error}, 9'h006);
    abort <= 1'b1;
    xfer(mk(EXT_LOW, 1'b0, SIZE_WORD, 1'b0));
    abort <= 1'b0;
    check({got.aborted, s.rd, s.dir_low}, 3'h6);
  endtask

  task t_monitor;
    int lim;
    delay = 8'hff;
    for (int t = 0; t < 4; t++) begin
      lim = 8 << t;
      wb(1'b1, CTRL_OFFSET, t << CTRL_TMO_LSB);
      xfer(mk(EXT_LOW, 1'b0, SIZE_WORD, 1'b0));
      check(got.error, 1'b1);
      check(s.n >= lim && s.n <= lim + 4, 1'b1);
    end
    wb(1'b1, CTRL_OFFSET, 32'h0);
  endtask

  task t_split;
    req_type r;
    delay = 8'h00;
    r = mk(EXT_LOW + 32'h20, 1'b0, SIZE_WORD, 1'b0);
    r.port16 = 1'b1;
    xfer(r);
    check({s.a1, s.lanes}, 5'h1c);
    check(got.rdata, {PAT[31:16], PAT[31:16]});
  endtask

  task t_show;
    logic [31:0] ctl [3] = '{32'h1, 32'h0, 32'h8};
    logic [31:0] ad  [3] = '{32'h0000_1000, PORTS_LOW + 32'h10, 32'h00c1_0000};
    logic [1:0]  es  [3] = '{ESC_INTERNAL, ESC_PORTS, ESC_REGS};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, CTRL_OFFSET, ctl[i]);
      xfer(mk(ad[i], 1'b0, SIZE_WORD, 1'b1));
      check(s.oe, i == 1 ? 32'h0 : 32'hffff_ffff);
      check({s.lanes, s.rd, s.dir_low, s.n}, 14'h3c02);
      check(s.esc, es[i]);
      if (i != 1) check(s.dat, WDAT);
    end
    wb(1'b1, CTRL_OFFSET, 32'h0);
  endtask

  initial begin
    #(40 * 20000);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_read();
    t_write();
    t_term();
    t_monitor();
    t_split();
    t_show();
    print_verdict();
  end
endmodule
